// ### rtl/hts_pkg.sv
package hts_pkg;

	// Microprocessor port geometry
	localparam int HTS_ADDR_W = 5;
	localparam int HTS_PAGE_W = 8;
	localparam int HTS_DATA_W = 8;
	localparam int HTS_NUM_CTL = 2;

	// Register pages of the two controllers
	localparam logic [HTS_PAGE_W-1:0] HTS_PAGE_CTL0 = 8'h0B;
	localparam logic [HTS_PAGE_W-1:0] HTS_PAGE_CTL1 = 8'h0C;

	// Register offsets within a page
	localparam logic [HTS_ADDR_W-1:0] HTS_OFS_TEST_STATUS = 5'h1C;
	localparam logic [HTS_ADDR_W-1:0] HTS_OFS_LEVEL_SEL = 5'h1D;

	// Test status bit positions
	localparam int HTS_BIT_RX_CLK = 3;
	localparam int HTS_BIT_TX_CLK = 2;
	localparam int HTS_BIT_CRC_OK = 1;
	localparam int HTS_BIT_ADDR_OK = 0;

	// Level select field positions
	localparam int HTS_RX_SEL_LSB = 4;
	localparam int HTS_TX_SEL_LSB = 0;
	localparam int HTS_SEL_W = 3;

	// Reset values and level constants
	localparam logic [HTS_SEL_W-1:0] HTS_SEL_RESET = 3'h0;
	localparam logic [HTS_SEL_W-1:0] HTS_SEL_112 = 3'h6;
	localparam logic [HTS_DATA_W-1:0] HTS_LEVEL_112 = 8'h70;
	localparam logic [HTS_DATA_W-1:0] HTS_BYTE_ZERO = 8'h00;
	localparam logic [HTS_DATA_W-1:0] HTS_LEVEL_STEP = 8'h10;

	// Full-status level in bytes: sixteen per code step, code 0 gives 16
	function automatic logic [HTS_DATA_W-1:0] hts_level_of(input logic [HTS_SEL_W-1:0] sel);
		logic [HTS_DATA_W-1:0] steps;
		steps = {5'h00, sel} + 8'h01;
		return 8'(steps * HTS_LEVEL_STEP);
	endfunction

endpackage

// ### rtl/hts_bank.sv
`timescale 1ns/100ps
`default_nettype none

module hts_bank
	import hts_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Level register write
	input wire logic wr_en,
	input wire logic [HTS_DATA_W-1:0] wr_data,
	// Controller state
	input wire logic rx_bit_clk,
	input wire logic tx_bit_clk,
	input wire logic receiver_enable_ctl,
	input wire logic transmitter_enable_ctl,
	input wire logic crc_match,
	input wire logic addr_match,
	// Register images and levels
	output logic [HTS_DATA_W-1:0] status_byte,
	output logic [HTS_DATA_W-1:0] level_byte,
	output logic [HTS_DATA_W-1:0] rx_full_level,
	output logic [HTS_DATA_W-1:0] tx_full_level
);

	typedef struct packed {
		logic [1:0] rx_sync;
		logic [1:0] tx_sync;
		logic [HTS_DATA_W-1:0] status;
		logic [HTS_SEL_W-1:0] rx_sel;
		logic [HTS_SEL_W-1:0] tx_sel;
		logic [HTS_DATA_W-1:0] rx_lvl;
		logic [HTS_DATA_W-1:0] tx_lvl;
	} hts_bank_type;

	hts_bank_type s_reg;
	hts_bank_type s_next;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_next = s_reg;
		// Bit clocks are foreign; only the second stage feeds logic
		s_next.rx_sync = {s_reg.rx_sync[0], rx_bit_clk};
		s_next.tx_sync = {s_reg.tx_sync[0], tx_bit_clk};
		s_next.status = HTS_BYTE_ZERO;
		s_next.status[HTS_BIT_RX_CLK] = s_reg.rx_sync[1] & receiver_enable_ctl;
		s_next.status[HTS_BIT_TX_CLK] = s_reg.tx_sync[1] & transmitter_enable_ctl;
		s_next.status[HTS_BIT_CRC_OK] = crc_match;
		s_next.status[HTS_BIT_ADDR_OK] = addr_match;
		if (wr_en)
		begin
			s_next.rx_sel = wr_data[HTS_RX_SEL_LSB +: HTS_SEL_W];
			s_next.tx_sel = wr_data[HTS_TX_SEL_LSB +: HTS_SEL_W];
			s_next.rx_lvl = hts_level_of(wr_data[HTS_RX_SEL_LSB +: HTS_SEL_W]);
			s_next.tx_lvl = hts_level_of(wr_data[HTS_TX_SEL_LSB +: HTS_SEL_W]);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.rx_sel <= HTS_SEL_RESET;
			s_reg.tx_sel <= HTS_SEL_RESET;
			s_reg.rx_lvl <= HTS_LEVEL_STEP;
			s_reg.tx_lvl <= HTS_LEVEL_STEP;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign status_byte = s_reg.status;
	// Unused bits 7 and 3 read as zero
	assign level_byte = {1'b0, s_reg.rx_sel, 1'b0, s_reg.tx_sel};
	assign rx_full_level = s_reg.rx_lvl;
	assign tx_full_level = s_reg.tx_lvl;

	////////////////////////////////////////////////////////////////////////////////

	property p_rx_tap;
		@(posedge sys_clk) disable iff (rst)
		##1 status_byte[HTS_BIT_RX_CLK] == ($past(s_reg.rx_sync[1]) && $past(receiver_enable_ctl));
	endproperty
	a_rx_tap: assert property (p_rx_tap) else $error("rx clock tap wrong");

	property p_tx_tap;
		@(posedge sys_clk) disable iff (rst)
		!transmitter_enable_ctl |=> !status_byte[HTS_BIT_TX_CLK];
	endproperty
	a_tx_tap: assert property (p_tx_tap) else $error("tx clock tap not gated");

	property p_crc;
		@(posedge sys_clk) disable iff (rst)
		crc_match |=> status_byte[HTS_BIT_CRC_OK];
	endproperty
	a_crc: assert property (p_crc) else $error("crc status missed");

	property p_addr;
		@(posedge sys_clk) disable iff (rst)
		!addr_match |=> !status_byte[HTS_BIT_ADDR_OK];
	endproperty
	a_addr: assert property (p_addr) else $error("address status wrong");

	property p_rx_level;
		@(posedge sys_clk) disable iff (rst)
		wr_en |=> rx_full_level == {1'b0, $past(wr_data[6:4]), 4'h0} + HTS_LEVEL_STEP
			&& level_byte[6:4] == $past(wr_data[6:4]);
	endproperty
	a_rx_level: assert property (p_rx_level) else $error("rx level not taken");

	property p_tx_level;
		@(posedge sys_clk) disable iff (rst)
		wr_en |=> tx_full_level == {1'b0, $past(wr_data[2:0]), 4'h0} + HTS_LEVEL_STEP;
	endproperty
	a_tx_level: assert property (p_tx_level) else $error("tx level not taken");

	property p_rx_112;
		@(posedge sys_clk) disable iff (rst)
		level_byte[6:4] == HTS_SEL_112 |-> rx_full_level == HTS_LEVEL_112;
	endproperty
	a_rx_112: assert property (p_rx_112) else $error("rx code 6 not 112");

	property p_reset_levels;
		@(posedge sys_clk)
		rst |=> level_byte == HTS_BYTE_ZERO && rx_full_level == HTS_LEVEL_STEP
			&& tx_full_level == HTS_LEVEL_STEP;
	endproperty
	a_reset_levels: assert property (p_reset_levels) else $error("level reset wrong");

	property p_hold_levels;
		@(posedge sys_clk) disable iff (rst)
		!wr_en |=> $stable(level_byte);
	endproperty
	a_hold_levels: assert property (p_hold_levels) else $error("level changed without write");

endmodule

`default_nettype wire

// ### rtl/hts_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - status bit 3 shows gated receive clock
// - status bit 2 shows gated transmit clock
// - status bit 1 is receive CRC match
// - status bit 0 is address match
// - bits 6-4 pick receive level, 16-byte steps
// - bits 2-0 pick transmit level, 16-byte steps
module hts_regs
	import hts_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Microprocessor port pins
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [HTS_PAGE_W-1:0] page,
	input wire logic [HTS_ADDR_W-1:0] addr,
	input wire logic [HTS_DATA_W-1:0] data_in,
	output logic [HTS_DATA_W-1:0] data_out,
	output logic data_oe,
	// Per-controller state, index 0 is the first page
	input wire logic [HTS_NUM_CTL-1:0] rx_bit_clk,
	input wire logic [HTS_NUM_CTL-1:0] tx_bit_clk,
	input wire logic [HTS_NUM_CTL-1:0] receiver_enable_ctl,
	input wire logic [HTS_NUM_CTL-1:0] transmitter_enable_ctl,
	input wire logic [HTS_NUM_CTL-1:0] crc_match,
	input wire logic [HTS_NUM_CTL-1:0] addr_match,
	// Selected full-status levels in bytes
	output logic [HTS_NUM_CTL-1:0][HTS_DATA_W-1:0] rx_full_level,
	output logic [HTS_NUM_CTL-1:0][HTS_DATA_W-1:0] tx_full_level
);

	typedef struct packed {
		logic [1:0] cs_n_s;
		logic [1:0] rd_n_s;
		logic [1:0] wr_n_s;
		logic wr_n_prev;
		logic [1:0][HTS_PAGE_W-1:0] page_s;
		logic [1:0][HTS_ADDR_W-1:0] addr_s;
		logic [1:0][HTS_DATA_W-1:0] din_s;
		logic [HTS_DATA_W-1:0] dout;
		logic oe;
	} hts_port_type;

	hts_port_type p_reg;
	hts_port_type p_next;

	logic [HTS_NUM_CTL-1:0] bank_wr;
	logic [HTS_NUM_CTL-1:0][HTS_DATA_W-1:0] status_byte;
	logic [HTS_NUM_CTL-1:0][HTS_DATA_W-1:0] level_byte;
	logic wr_fall;

	// Page decode, shared by read and write paths
	function automatic logic [HTS_NUM_CTL-1:0] hts_page_hit(input logic [HTS_PAGE_W-1:0] pg);
		logic [HTS_NUM_CTL-1:0] hit;
		hit = '0;
		hit[0] = (pg == HTS_PAGE_CTL0);
		hit[1] = (pg == HTS_PAGE_CTL1);
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Write is taken once, on the falling write strobe; data must be settled by then
	assign wr_fall = p_reg.wr_n_prev & ~p_reg.wr_n_s[1] & ~p_reg.cs_n_s[1];
	assign bank_wr = (wr_fall && p_reg.addr_s[1] == HTS_OFS_LEVEL_SEL)
		? hts_page_hit(p_reg.page_s[1]) : '0;

	generate
		for (genvar i = 0; i < HTS_NUM_CTL; i++)
		begin : g_bank
			hts_bank u_bank (
				.sys_clk(sys_clk),
				.rst(rst),
				.wr_en(bank_wr[i]),
				.wr_data(p_reg.din_s[1]),
				.rx_bit_clk(rx_bit_clk[i]),
				.tx_bit_clk(tx_bit_clk[i]),
				.receiver_enable_ctl(receiver_enable_ctl[i]),
				.transmitter_enable_ctl(transmitter_enable_ctl[i]),
				.crc_match(crc_match[i]),
				.addr_match(addr_match[i]),
				.status_byte(status_byte[i]),
				.level_byte(level_byte[i]),
				.rx_full_level(rx_full_level[i]),
				.tx_full_level(tx_full_level[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic [HTS_NUM_CTL-1:0] hit;
		hit = hts_page_hit(p_reg.page_s[1]);
		p_next = p_reg;
		p_next.cs_n_s = {p_reg.cs_n_s[0], cs_n};
		p_next.rd_n_s = {p_reg.rd_n_s[0], rd_n};
		p_next.wr_n_s = {p_reg.wr_n_s[0], wr_n};
		p_next.wr_n_prev = p_reg.wr_n_s[1];
		p_next.page_s = {p_reg.page_s[0], page};
		p_next.addr_s = {p_reg.addr_s[0], addr};
		p_next.din_s = {p_reg.din_s[0], data_in};
		p_next.dout = HTS_BYTE_ZERO;
		p_next.oe = 1'b0;
		// Only the two owned addresses drive the bus; others belong elsewhere
		if (!p_reg.cs_n_s[1] && !p_reg.rd_n_s[1] && hit != '0)
		begin
			for (int i = 0; i < HTS_NUM_CTL; i++)
			begin
				if (hit[i])
				begin
					case (p_reg.addr_s[1])
						HTS_OFS_TEST_STATUS:
						begin
							p_next.dout = status_byte[i];
							p_next.oe = 1'b1;
						end
						HTS_OFS_LEVEL_SEL:
						begin
							p_next.dout = level_byte[i];
							p_next.oe = 1'b1;
						end
						default:
						begin
							p_next.dout = HTS_BYTE_ZERO;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			p_reg <= '0;
			p_reg.cs_n_s <= 2'h3;
			p_reg.rd_n_s <= 2'h3;
			p_reg.wr_n_s <= 2'h3;
			p_reg.wr_n_prev <= 1'b1;
		end
		else
		begin
			p_reg <= p_next;
		end
	end

	assign data_out = p_reg.dout;
	assign data_oe = p_reg.oe;

	////////////////////////////////////////////////////////////////////////////////

	// Status read hands over the image of the edge before
	property p_read_status;
		@(posedge sys_clk) disable iff (rst)
		!p_reg.cs_n_s[1] && !p_reg.rd_n_s[1] && p_reg.page_s[1] == HTS_PAGE_CTL1
			&& p_reg.addr_s[1] == HTS_OFS_TEST_STATUS
			|=> data_oe && data_out == $past(status_byte[1]);
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_read_level;
		@(posedge sys_clk) disable iff (rst)
		!p_reg.cs_n_s[1] && !p_reg.rd_n_s[1] && p_reg.page_s[1] == HTS_PAGE_CTL0
			&& p_reg.addr_s[1] == HTS_OFS_LEVEL_SEL
			|=> data_oe && data_out == $past(level_byte[0]);
	endproperty
	a_read_level: assert property (p_read_level) else $error("level read wrong");

	// No drive without read strobe; idle bus shows zero
	property p_idle_release;
		@(posedge sys_clk) disable iff (rst)
		p_reg.rd_n_s[1] |=> !data_oe && data_out == HTS_BYTE_ZERO;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("bus driven without read");

	// Pages of neither controller are never driven
	property p_foreign_page;
		@(posedge sys_clk) disable iff (rst)
		hts_page_hit(p_reg.page_s[1]) == '0 |=> !data_oe;
	endproperty
	a_foreign_page: assert property (p_foreign_page) else $error("foreign page driven");

	// Drive only starts after both strobes were seen low
	property p_drive_cause;
		@(posedge sys_clk) disable iff (rst)
		$rose(data_oe) |-> !$past(p_reg.rd_n_s[1]) && !$past(p_reg.cs_n_s[1]);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("drive without strobes");

	// A taken write lands in the addressed controller only
	property p_write_ctl1;
		@(posedge sys_clk) disable iff (rst)
		wr_fall && p_reg.addr_s[1] == HTS_OFS_LEVEL_SEL && p_reg.page_s[1] == HTS_PAGE_CTL1
			|=> level_byte[1][HTS_RX_SEL_LSB +: HTS_SEL_W]
				== $past(p_reg.din_s[1][HTS_RX_SEL_LSB +: HTS_SEL_W])
			&& $stable(level_byte[0]);
	endproperty
	a_write_ctl1: assert property (p_write_ctl1) else $error("controller 1 write wrong");

	property p_write_ctl0;
		@(posedge sys_clk) disable iff (rst)
		wr_fall && p_reg.addr_s[1] == HTS_OFS_LEVEL_SEL && p_reg.page_s[1] == HTS_PAGE_CTL0
			|=> level_byte[0][HTS_TX_SEL_LSB +: HTS_SEL_W]
				== $past(p_reg.din_s[1][HTS_TX_SEL_LSB +: HTS_SEL_W])
			&& $stable(level_byte[1]);
	endproperty
	a_write_ctl0: assert property (p_write_ctl0) else $error("controller 0 write wrong");

	// Status address is read only
	property p_status_ro;
		@(posedge sys_clk) disable iff (rst)
		wr_fall && p_reg.addr_s[1] == HTS_OFS_TEST_STATUS |=> $stable(level_byte);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write took effect");

endmodule

`default_nettype wire

// ### sim/hts_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
	begin check_count++; if ((g) !== (e)) begin \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); miscompares++; end end

module hts_regs_tb
	import hts_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst, cs_n, rd_n, wr_n, seen;
	logic [7:0] page, data_in, data_out, d;
	logic [4:0] addr;
	logic data_oe;
	logic [1:0] rx_bit_clk, tx_bit_clk, rx_en, tx_en, crc_match, addr_match;
	logic [1:0][7:0] rx_full_level, tx_full_level;
	int miscompares = 0;
	int check_count = 0;
	// Rows: written byte, read-back byte, rx level, tx level; row 3 sets unused bits
	logic [31:0] rows [8] = '{32'h07071080, 32'h16162070, 32'h25253060, 32'hBC344050,
		32'h43435040, 32'h52526030, 32'h61617020, 32'h70708010};

	always #2 sys_clk = ~sys_clk;

	hts_regs dut_u (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.page(page), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.rx_bit_clk(rx_bit_clk), .tx_bit_clk(tx_bit_clk), .receiver_enable_ctl(rx_en),
		.transmitter_enable_ctl(tx_en), .crc_match(crc_match), .addr_match(addr_match),
		.rx_full_level(rx_full_level), .tx_full_level(tx_full_level));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Address and data settle through the synchronisers before the strobe falls
	task automatic wr(input logic [7:0] pg, input logic [4:0] ad, input logic [7:0] v);
		page = pg;
		addr = ad;
		data_in = v;
		cs_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		wr_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		wr_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		cs_n = 1'b1;
		@(negedge sys_clk);
	endtask

	task automatic rdx(input logic [7:0] pg, input logic [4:0] ad, input logic [7:0] e);
		int n;
		page = pg;
		addr = ad;
		cs_n = 1'b0;
		rd_n = 1'b0;
		seen = 1'b0;
		for (n = 0; n < 8 && !seen; n++)
		begin
			@(negedge sys_clk);
			if (data_oe === 1'b1)
			begin
				seen = 1'b1;
				d = data_out;
			end
		end
		cs_n = 1'b1;
		rd_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		if (!seen)
		begin
			$display("wrong value read strobe expected 1 seen 0");
			miscompares++;
			final_report();
		end
		else
			`CHK("read data", e, d)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		page = 8'h00;
		addr = 5'h00;
		data_in = 8'h00;
		d = 8'h00;
		{rx_bit_clk, tx_bit_clk, rx_en, tx_en, crc_match, addr_match} = 12'h000;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		`CHK("rx level", 8'h10, rx_full_level[0])
		`CHK("tx level", 8'h10, tx_full_level[1])
		rdx(HTS_PAGE_CTL1, HTS_OFS_LEVEL_SEL, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			wr(HTS_PAGE_CTL0, HTS_OFS_LEVEL_SEL, rows[i][31:24]);
			`CHK("rx level", rows[i][15:8], rx_full_level[0])
			`CHK("tx level", rows[i][7:0], tx_full_level[0])
			rdx(HTS_PAGE_CTL0, HTS_OFS_LEVEL_SEL, rows[i][23:16]);
		end
		// Foreign page and read-only status must not reach the second controller
		wr(8'h0D, HTS_OFS_LEVEL_SEL, 8'h77);
		wr(HTS_PAGE_CTL1, HTS_OFS_TEST_STATUS, 8'h77);
		`CHK("rx level 1", 8'h10, rx_full_level[1])
		`CHK("tx level 1", 8'h10, tx_full_level[1])
		// Second controller takes its own write and leaves the first alone
		wr(HTS_PAGE_CTL1, HTS_OFS_LEVEL_SEL, 8'h52);
		`CHK("rx level 1", 8'h60, rx_full_level[1])
		`CHK("tx level 1", 8'h30, tx_full_level[1])
		`CHK("rx level 0", 8'h80, rx_full_level[0])
		`CHK("tx level 0", 8'h10, tx_full_level[0])
		rdx(HTS_PAGE_CTL1, HTS_OFS_LEVEL_SEL, 8'h52);
		rx_bit_clk = 2'h2;
		tx_bit_clk = 2'h2;
		rx_en = 2'h2;
		crc_match = 2'h2;
		repeat (4) @(negedge sys_clk);
		rdx(HTS_PAGE_CTL1, HTS_OFS_TEST_STATUS, 8'h0A);
		rdx(HTS_PAGE_CTL0, HTS_OFS_TEST_STATUS, 8'h00);
		rx_en = 2'h0;
		tx_en = 2'h2;
		crc_match = 2'h0;
		addr_match = 2'h2;
		repeat (4) @(negedge sys_clk);
		rdx(HTS_PAGE_CTL1, HTS_OFS_TEST_STATUS, 8'h05);
		`CHK("drive after read", 1'b0, data_oe)
		// Reads outside the two owned registers leave the bus undriven
		for (int k = 0; k < 2; k++)
		begin
			page = k ? 8'h0D : HTS_PAGE_CTL0;
			addr = k ? HTS_OFS_LEVEL_SEL : 5'h1B;
			cs_n = 1'b0;
			rd_n = 1'b0;
			repeat (4) @(negedge sys_clk);
			`CHK("unowned drive", 1'b0, data_oe)
			`CHK("unowned data", 8'h00, data_out)
			cs_n = 1'b1;
			rd_n = 1'b1;
			repeat (4) @(negedge sys_clk);
		end
		// Second reset in mid-run returns the levels to their reset codes
		rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		`CHK("rx level", 8'h10, rx_full_level[0])
		`CHK("tx level 1", 8'h10, tx_full_level[1])
		rdx(HTS_PAGE_CTL0, HTS_OFS_LEVEL_SEL, 8'h00);
		rdx(HTS_PAGE_CTL1, HTS_OFS_LEVEL_SEL, 8'h00);
		final_report();
	end
endmodule

`default_nettype wire
